/* File: rtl/chmc_top.sv */
// supervisory digital control of the single-cell charger
`include "chmc_defines.svh"

module chmc_top #(
    parameter int TICK_CYC = `CHMC_TICK_NS / `CHMC_CLK_NS,
    parameter int BOOST_DLY_MS = `CHMC_BOOST_DLY_MS,
    parameter int BOOST_PFM_MS = `CHMC_BOOST_PFM_MS,
    parameter int WDT_MS = `CHMC_WDT_MS,
    parameter int SAFETY_MS = `CHMC_SAFETY_MS,
    parameter int BLINK_MS = `CHMC_BLINK_MS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic source_select_pin,
    input wire logic charge_enable_pin_n,
    input wire chmc_pkg::chmc_sense_t sense,
    output chmc_pkg::chmc_drive_t drive,
    output logic status_pin_o,
    output logic status_pin_oe,
    output logic host_interrupt_pin
);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    chmc_pkg::chmc_sense_t sn1_ff, sn_ff;
    logic [1:0] pin1_ff, pin_ff;
    logic sel_prev_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sn1_ff <= '0;
            sn_ff <= '0;
            pin1_ff <= 2'h3;
            pin_ff <= 2'h3;
            sel_prev_ff <= 1'b1;
        end else begin
            sn1_ff <= sense;
            sn_ff <= sn1_ff;
            pin1_ff <= {charge_enable_pin_n, source_select_pin};
            pin_ff <= pin1_ff;
            sel_prev_ff <= pin_ff[0];
        end
    end

    wire logic sel_pin = pin_ff[0];
    wire logic ce_n = pin_ff[1];

    // ----------------------------------------
    // millisecond tick
    // ----------------------------------------
    logic [31:0] tick_cnt_ff;
    logic tick_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (tick_cnt_ff == 32'(TICK_CYC - 1));
            tick_cnt_ff <= (tick_cnt_ff == 32'(TICK_CYC - 1)) ? '0 : tick_cnt_ff + 32'h1;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [5:0] icl_ff;
    logic [6:0] vlim_ff;
    logic [7:0] ctl_ff, fast_charge_current_ff, preterm_ff, vreg_ff;
    logic [5:0] sw_ff;
    logic [2:0] src_ff;
    logic host_ff, wd_exp, det_done_ff;

    wire logic wr_cmd = reg_wr && reg_addr == `CHMC_A_CMD;
    wire logic kick = wr_cmd && reg_wdata[`CHMC_CMD_KICK];
    wire logic trig = wr_cmd && reg_wdata[`CHMC_CMD_DETECT];
    wire logic det_ev = sn_ff.vbus_good && !det_done_ff;
    wire logic pin_chg = !host_ff && det_done_ff && sel_pin != sel_prev_ff;
    wire logic load_icl = det_ev || pin_chg || (trig && host_ff);
    wire logic chg_en_bit = ctl_ff[`CHMC_CTL_CHG_EN];
    wire logic pulse_freq_disable = ctl_ff[`CHMC_CTL_PULSE_FREQ_DISABLE];
    wire logic boost_en = ctl_ff[`CHMC_CTL_BOOST_EN];
    wire logic [1:0] track_sel = ctl_ff[5:4];
    wire logic [1:0] wd_period = ctl_ff[7:6];
    wire logic force_off = sw_ff[2];
    wire logic rechg_sel = sw_ff[3];
    wire logic [1:0] stat_ctl = sw_ff[5:4];

    // limit and status kept through a supervision expiry
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            icl_ff <= `CHMC_ICL_DEF;
            vlim_ff <= `CHMC_VLIM_DEF;
            src_ff <= `CHMC_SRC_NONE;
        end else begin
            if (load_icl) begin
                icl_ff <= sel_pin ? `CHMC_ICL_USB : `CHMC_ICL_ADP;
                src_ff <= sel_pin ? `CHMC_SRC_USB : `CHMC_SRC_ADP;
            end else if (reg_wr && reg_addr == `CHMC_A_ICL) begin
                icl_ff <= reg_wdata[5:0];
            end
            if (!sn_ff.vbus_good) begin
                src_ff <= `CHMC_SRC_NONE;
            end
            if (reg_wr && reg_addr == `CHMC_A_VLIM) begin
                vlim_ff <= reg_wdata[6:0];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl_ff <= `CHMC_CTL_DEF;
            sw_ff <= `CHMC_SW_DEF;
            fast_charge_current_ff <= `CHMC_FAST_CHARGE_CURRENT_DEF;
            preterm_ff <= `CHMC_PRETERM_DEF;
            vreg_ff <= `CHMC_VREG_DEF;
        end else if (wd_exp) begin
            ctl_ff <= `CHMC_CTL_DEF;
            sw_ff[5:3] <= 3'(`CHMC_SW_DEF >> 3);
            fast_charge_current_ff <= `CHMC_FAST_CHARGE_CURRENT_DEF;
            preterm_ff <= `CHMC_PRETERM_DEF;
            vreg_ff <= `CHMC_VREG_DEF;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `CHMC_A_CTL: ctl_ff <= reg_wdata;
                `CHMC_A_SW: sw_ff <= reg_wdata[5:0];
                `CHMC_A_FAST_CHARGE_CURRENT: fast_charge_current_ff <= reg_wdata;
                `CHMC_A_PRETERM: preterm_ff <= reg_wdata;
                `CHMC_A_VREG: vreg_ff <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // supervision timer and mode
    // ----------------------------------------
    function automatic logic [31:0] wd_limit(input logic [1:0] p);
        logic [31:0] base;
        base = 32'(WDT_MS);
        return base << (p - 2'h1);
    endfunction

    logic [31:0] wd_cnt_ff;
    assign wd_exp = host_ff && wd_period != 2'h0 && tick_ff
                    && wd_cnt_ff + 32'h1 >= wd_limit(wd_period);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_ff <= 1'b0;
            wd_cnt_ff <= '0;
        end else if (kick) begin
            host_ff <= 1'b1;
            wd_cnt_ff <= '0;
        end else if (wd_exp) begin
            host_ff <= 1'b0;
            wd_cnt_ff <= '0;
        end else if (host_ff && wd_period != 2'h0 && tick_ff) begin
            wd_cnt_ff <= wd_cnt_ff + 32'h1;
        end
    end

    // ----------------------------------------
    // power-up and converter
    // ----------------------------------------
    logic conv_en_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            det_done_ff <= 1'b0;
            conv_en_ff <= 1'b0;
        end else begin
            det_done_ff <= sn_ff.vbus_good;
            // one cycle behind detection, so the limit is already loaded
            conv_en_ff <= det_done_ff && sn_ff.vbus_good;
        end
    end

    // ----------------------------------------
    // boost
    // ----------------------------------------
    logic [15:0] bst_cnt_ff;
    wire logic bst_ok = sn_ff.bat_above_boost && sn_ff.vbus_below_sleep
                        && boost_en && sn_ff.ts_ok;
    wire logic bst_on = bst_ok && bst_cnt_ff >= 16'(BOOST_DLY_MS);
    wire logic bst_pfm = bst_cnt_ff < 16'(BOOST_DLY_MS + BOOST_PFM_MS);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bst_cnt_ff <= '0;
        end else if (!boost_en) begin
            bst_cnt_ff <= '0;
        end else if (tick_ff && bst_pfm) begin
            bst_cnt_ff <= bst_cnt_ff + 16'h1;
        end
    end

    // ----------------------------------------
    // charge cycle
    // ----------------------------------------
    chmc_pkg::chmc_state_t st_ff;
    logic [31:0] safe_cnt_ff;
    logic safe_flt_ff;
    wire logic en_all = chg_en_bit && !ce_n;
    wire logic can_chg = conv_en_ff && en_all && fast_charge_current_ff != 8'h00 && sn_ff.ts_ok
                         && !safe_flt_ff && !force_off;
    wire logic above_rechg = rechg_sel ? sn_ff.bat_above_rechg_hi : sn_ff.bat_above_rechg_lo;
    wire logic term = sn_ff.term_low && above_rechg && !sn_ff.in_regulation;
    wire logic done_ev = st_ff == chmc_pkg::CHMC_CHARGE && can_chg && term;
    wire logic fault = safe_flt_ff || (en_all && !sn_ff.ts_ok);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= chmc_pkg::CHMC_IDLE;
        end else begin
            unique case (st_ff)
                chmc_pkg::CHMC_IDLE: if (can_chg) begin
                    st_ff <= chmc_pkg::CHMC_CHARGE;
                end else if (fault) begin
                    st_ff <= chmc_pkg::CHMC_FAULT;
                end
                chmc_pkg::CHMC_CHARGE: if (fault) begin
                    st_ff <= chmc_pkg::CHMC_FAULT;
                end else if (!can_chg) begin
                    st_ff <= chmc_pkg::CHMC_IDLE;
                end else if (term) begin
                    st_ff <= chmc_pkg::CHMC_DONE;
                end
                // disabling here is how a toggle restarts the cycle
                chmc_pkg::CHMC_DONE: if (!can_chg) begin
                    st_ff <= chmc_pkg::CHMC_IDLE;
                end else if (!above_rechg) begin
                    st_ff <= chmc_pkg::CHMC_CHARGE;
                end
                chmc_pkg::CHMC_FAULT: if (!fault) begin
                    st_ff <= chmc_pkg::CHMC_IDLE;
                end
            endcase
        end
    end

    // safety timer; fault holds until charging is disabled
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            safe_cnt_ff <= '0;
            safe_flt_ff <= 1'b0;
        end else if (!en_all) begin
            safe_cnt_ff <= '0;
            safe_flt_ff <= 1'b0;
        end else if (st_ff == chmc_pkg::CHMC_CHARGE && tick_ff) begin
            if (safe_cnt_ff + 32'h1 >= 32'(SAFETY_MS)) begin
                safe_flt_ff <= 1'b1;
            end
            safe_cnt_ff <= safe_cnt_ff + 32'h1;
        end
    end

    function automatic logic [1:0] phase(input chmc_pkg::chmc_state_t s, input logic pre);
        logic [1:0] p;
        p = 2'h0;
        if (s == chmc_pkg::CHMC_CHARGE) begin
            p = pre ? 2'h1 : 2'h2;
        end else if (s == chmc_pkg::CHMC_DONE) begin
            p = 2'h3;
        end
        return p;
    endfunction

    // ----------------------------------------
    // interrupt pulse
    // ----------------------------------------
    logic [1:0] pend_ff;
    logic [7:0] int_cnt_ff;
    wire logic int_go = int_cnt_ff == 8'h00 && pend_ff != 2'h0;
    wire logic [1:0] take = !int_go ? 2'h0 : pend_ff[0] ? 2'h1 : 2'h2;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_ff <= '0;
            int_cnt_ff <= '0;
            host_interrupt_pin <= 1'b0;
        end else begin
            // a new event beats the clear of the one being sent
            pend_ff <= (pend_ff & ~take) | {done_ev, det_ev};
            if (int_go) begin
                int_cnt_ff <= 8'(`CHMC_INT_PULSE_CYC);
            end else if (int_cnt_ff != 8'h00) begin
                int_cnt_ff <= int_cnt_ff - 8'h1;
            end
            host_interrupt_pin <= int_go || int_cnt_ff > 8'h1;
        end
    end

    // ----------------------------------------
    // status pin
    // ----------------------------------------
    logic [15:0] blk_cnt_ff;
    logic blk_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            blk_cnt_ff <= '0;
            blk_ff <= 1'b0;
            status_pin_o <= 1'b1;
            status_pin_oe <= 1'b0;
        end else begin
            if (tick_ff) begin
                blk_cnt_ff <= (blk_cnt_ff + 16'h1 >= 16'(BLINK_MS)) ? '0 : blk_cnt_ff + 16'h1;
                blk_ff <= blk_ff ^ (blk_cnt_ff + 16'h1 >= 16'(BLINK_MS));
            end
            status_pin_oe <= stat_ctl != `CHMC_STATPIN_OFF;
            status_pin_o <= fault ? blk_ff : st_ff != chmc_pkg::CHMC_CHARGE;
        end
    end

    // ----------------------------------------
    // power stage drive
    // ----------------------------------------
    function automatic logic [6:0] track_off(input logic [1:0] s);
        return (s == 2'h0) ? 7'h0 : 7'({s, 1'b0});
    endfunction

    wire logic [6:0] trk = 7'(sn_ff.bat_volt + track_off(track_sel));
    wire logic [5:0] soft_icl = icl_ff < `CHMC_ICL_SOFT ? icl_ff : `CHMC_ICL_SOFT;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            drive <= '0;
            drive.battery_switch <= 1'b1;
            drive.eff_icl <= `CHMC_ICL_DEF;
            drive.eff_vlim <= `CHMC_VLIM_DEF;
        end else begin
            drive.converter_en <= conv_en_ff;
            drive.battery_switch <= !force_off
                && !(conv_en_ff && st_ff != chmc_pkg::CHMC_CHARGE);
            drive.charging <= st_ff == chmc_pkg::CHMC_CHARGE;
            drive.boost_active <= bst_on;
            drive.boost_ilim_hi <= ctl_ff[`CHMC_CTL_BOOST_ISEL];
            drive.boost_vset_mv <= `CHMC_BOOST_MV;
            drive.pfm_mode <= !pulse_freq_disable && (bst_on ? bst_pfm : sn_ff.light_load
                && (sn_ff.bat_low_minsys || !chg_en_bit));
            drive.eff_icl <= sn_ff.sys_low ? soft_icl : icl_ff;
            drive.eff_vlim <= (track_sel != 2'h0 && trk > vlim_ff) ? trk : vlim_ff;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    logic [7:0] rd_val;

    always_comb begin
        rd_val = 8'h00;
        unique case (reg_addr)
            `CHMC_A_ICL: rd_val = {2'h0, icl_ff};
            `CHMC_A_VLIM: rd_val = {1'b0, vlim_ff};
            `CHMC_A_CTL: rd_val = ctl_ff;
            `CHMC_A_SW: rd_val = {2'h0, sw_ff};
            `CHMC_A_FAST_CHARGE_CURRENT: rd_val = fast_charge_current_ff;
            `CHMC_A_PRETERM: rd_val = preterm_ff;
            `CHMC_A_VREG: rd_val = vreg_ff;
            `CHMC_A_STAT: rd_val = {safe_flt_ff, !host_ff, det_done_ff,
                phase(st_ff, sn_ff.bat_precharge),
                bst_on ? `CHMC_SRC_BOOST : src_ff};
            `CHMC_A_EICL: rd_val = {2'h0, drive.eff_icl};
            `CHMC_A_EVLIM: rd_val = {1'b0, drive.eff_vlim};
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_val : 8'h00;
        end
    end

endmodule

/* File: pkg/chmc_defines.svh */
// register map, reset values and timing constants of the charger mode control
`ifndef CHMC_DEFINES_SVH
`define CHMC_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CHMC_A_ICL 4'h0
`define CHMC_A_VLIM 4'h1
`define CHMC_A_CTL 4'h2
`define CHMC_A_SW 4'h3
`define CHMC_A_FAST_CHARGE_CURRENT 4'h4
`define CHMC_A_PRETERM 4'h5
`define CHMC_A_VREG 4'h6
`define CHMC_A_CMD 4'h7
`define CHMC_A_STAT 4'h8
`define CHMC_A_EICL 4'h9
`define CHMC_A_EVLIM 4'hA

// ----------------------------------------
// field positions
// ----------------------------------------
`define CHMC_CTL_CHG_EN 0
`define CHMC_CTL_PULSE_FREQ_DISABLE 1
`define CHMC_CTL_BOOST_EN 2
`define CHMC_CTL_BOOST_ISEL 3
`define CHMC_CMD_DETECT 0
`define CHMC_CMD_KICK 1

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define CHMC_ICL_DEF 6'h05
`define CHMC_ICL_USB 6'h05
`define CHMC_ICL_ADP 6'h18
`define CHMC_ICL_SOFT 6'h02
`define CHMC_VLIM_DEF 7'h2D
`define CHMC_CTL_DEF 8'h41
`define CHMC_SW_DEF 6'h01
`define CHMC_FAST_CHARGE_CURRENT_DEF 8'h20
`define CHMC_PRETERM_DEF 8'h33
`define CHMC_VREG_DEF 8'h0B
`define CHMC_SRC_NONE 3'h0
`define CHMC_SRC_USB 3'h1
`define CHMC_SRC_ADP 3'h3
`define CHMC_SRC_BOOST 3'h7
`define CHMC_STATPIN_OFF 2'h3
`define CHMC_BOOST_MV 13'h141E

// ----------------------------------------
// timing
// ----------------------------------------
`define CHMC_CLK_NS 100
`define CHMC_TICK_NS 1000000
`define CHMC_INT_PULSE_NS 1000
`define CHMC_INT_PULSE_CYC (`CHMC_INT_PULSE_NS / `CHMC_CLK_NS)
`define CHMC_BOOST_DLY_MS 30
`define CHMC_BOOST_PFM_MS 5
`define CHMC_WDT_MS 40000
`define CHMC_SAFETY_MS 36000000
`define CHMC_BLINK_MS 500

`endif

/* File: pkg/chmc_pkg.sv */
// types shared by the charger mode control
package chmc_pkg;

    typedef enum logic [1:0] {
        CHMC_IDLE = 2'h0,
        CHMC_CHARGE = 2'h1,
        CHMC_DONE = 2'h3,
        CHMC_FAULT = 2'h2
    } chmc_state_t;

    // comparator outputs and the battery voltage from the analog side
    typedef struct packed {
        logic vbus_good;
        logic sys_low;
        logic light_load;
        logic bat_low_minsys;
        logic bat_precharge;
        logic bat_above_boost;
        logic vbus_below_sleep;
        logic ts_ok;
        logic term_low;
        logic bat_above_rechg_lo;
        logic bat_above_rechg_hi;
        logic in_regulation;
        logic [6:0] bat_volt;
    } chmc_sense_t;

    // controls to the power stage
    typedef struct packed {
        logic converter_en;
        logic battery_switch;
        logic charging;
        logic boost_active;
        logic boost_ilim_hi;
        logic [12:0] boost_vset_mv;
        logic pfm_mode;
        logic [5:0] eff_icl;
        logic [6:0] eff_vlim;
    } chmc_drive_t;

endpackage

/* File: verif/chmc_props.sv */
// assertions on the ports of the charger mode control
module chmc_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic source_select_pin,
    input wire logic charge_enable_pin_n,
    input wire chmc_pkg::chmc_sense_t sense,
    input wire chmc_pkg::chmc_drive_t drive,
    input wire logic status_pin_o,
    input wire logic status_pin_oe,
    input wire logic host_interrupt_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // inputs pass two sync flops and a register, so five low samples are enough
    sequence s_low5(logic x);
        !x [*5];
    endsequence
    // pulse width counted here, a long repetition would be unrolled by the tools
    logic [4:0] int_hi_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_hi_ff <= 5'h00;
        end else begin
            int_hi_ff <= host_interrupt_pin ? int_hi_ff + 5'h01 : 5'h00;
        end
    end

    sequence s_int_end;
        $fell(host_interrupt_pin);
    endsequence

    property p_rd_answer;
        reg_rdata != 8'h00 |-> $past(reg_rd);
    endproperty
    property p_int_width;
        s_int_end |-> int_hi_ff == 5'h0A;
    endproperty
    property p_int_max;
        int_hi_ff <= 5'h0A;
    endproperty
    property p_boost_vset;
        drive.boost_active |-> drive.boost_vset_mv == 13'h141E;
    endproperty
    property p_boost_bat;
        s_low5(sense.bat_above_boost) |-> !drive.boost_active;
    endproperty
    property p_boost_ts;
        s_low5(sense.ts_ok) |-> !drive.boost_active;
    endproperty
    property p_boost_sleep;
        s_low5(sense.vbus_below_sleep) |-> !drive.boost_active;
    endproperty
    property p_soft_start;
        sense.sys_low [*5] ##0 drive.converter_en |-> drive.eff_icl <= 6'h02;
    endproperty
    // still charging one cycle on means the cycle before held no fault and no force-off
    property p_stat_low;
        drive.charging [*2] |-> !$past(status_pin_o);
    endproperty
    property p_switch_on;
        drive.charging [*2] |-> $past(drive.battery_switch);
    endproperty
    property p_chg_conv;
        drive.charging |-> $past(drive.converter_en);
    endproperty

    a_rd_answer: assert property (p_rd_answer) else $error("read data out of slot");
    a_int_width: assert property (p_int_width) else $error("bad pulse");
    a_int_max: assert property (p_int_max) else $error("pulse too long");
    a_boost_vset: assert property (p_boost_vset) else $error("boost level");
    a_boost_bat: assert property (p_boost_bat) else $error("boost on low bat");
    a_boost_ts: assert property (p_boost_ts) else $error("boost on hot");
    a_boost_sleep: assert property (p_boost_sleep) else $error("boost on vbus");
    a_soft_start: assert property (p_soft_start) else $error("no clamp");
    a_stat_low: assert property (p_stat_low) else $error("status high");
    a_switch_on: assert property (p_switch_on) else $error("switch off");
    a_chg_conv: assert property (p_chg_conv) else $error("charge w/o conv");
endmodule

bind chmc_top chmc_props chk_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .source_select_pin, .charge_enable_pin_n, .sense, .drive, .status_pin_o,
    .status_pin_oe, .host_interrupt_pin);

/* File: verif/chmc_host_model.sv */
// host processor model driving the register port
module chmc_host_model (
    input wire logic clk,
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // data is inverted after use so a stale value is never mistaken for a fresh one
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~v;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        v = reg_rdata;
    endtask
endmodule

/* File: verif/tb_chmc_top.sv */
// self-checking testbench of the charger mode control
module tb_chmc_top;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [3:0] a;
        logic [7:0] v;
    } chmc_row_t;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic source_select_pin = 1'b1;
    logic charge_enable_pin_n = 1'b0;
    chmc_pkg::chmc_sense_t sense = '{ts_ok: 1'b1, default: '0};
    chmc_pkg::chmc_drive_t drive;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic status_pin_o;
    logic status_pin_oe;
    logic host_interrupt_pin;
    logic [3:0] flags;
    logic [7:0] d;
    int n_errors = 0;
    int n_tests = 0;
    chmc_row_t rows [12] = '{'{4'h0, 8'h05}, '{4'h1, 8'h2D}, '{4'h2, 8'h41}, '{4'h3, 8'h01},
        '{4'h4, 8'h20}, '{4'h5, 8'h33}, '{4'h6, 8'h0B}, '{4'h7, 8'h00}, '{4'h9, 8'h05},
        '{4'hA, 8'h2D}, '{4'hB, 8'h00}, '{4'hF, 8'h00}};

    assign flags = {host_interrupt_pin, drive.charging, drive.boost_active, drive.converter_en};
    always #50 clk = ~clk;

    // short counts keep the run well inside the cycle budget
    chmc_top #(.TICK_CYC(10), .BOOST_DLY_MS(3), .WDT_MS(20),
        .SAFETY_MS(50), .BLINK_MS(4)) dut_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .source_select_pin, .charge_enable_pin_n, .sense, .drive,
        .status_pin_o, .status_pin_oe, .host_interrupt_pin);
    chmc_host_model far_u (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        far_u.rd(a, d);
        chk(d & m, e);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wait_flag(input int i, input logic v, input int lim);
        for (int k = 0; k < lim && flags[i] !== v; k++) @(posedge clk);
        chk(8'(flags[i]), 8'(v));
        if (flags[i] !== v) test_done();
    endtask

    initial begin
        cyc(2);
        sys_rst <= 1'b0;
        foreach (rows[i]) rdchk(rows[i].a, 8'hFF, rows[i].v);
        rdchk(4'h8, 8'h40, 8'h40);
        $display("end reset values");
        sense.vbus_good <= 1'b1;
        wait_flag(3, 1'b1, 20);
        cyc(12);
        rdchk(4'h8, 8'hFF, 8'h71);
        chk(8'({drive.charging, status_pin_o, status_pin_oe}), 8'h05);
        source_select_pin <= 1'b0;
        cyc(6);
        rdchk(4'h0, 8'hFF, 8'h18);
        rdchk(4'h8, 8'h07, 8'h03);
        rdchk(4'h9, 8'hFF, 8'h18);
        sense.sys_low <= 1'b1;
        cyc(4);
        rdchk(4'h9, 8'hFF, 8'h02);
        sense.sys_low <= 1'b0;
        $display("end detection");
        sense.term_low <= 1'b1;
        sense.bat_above_rechg_lo <= 1'b1;
        sense.bat_above_rechg_hi <= 1'b1;
        sense.in_regulation <= 1'b1;
        cyc(30);
        chk(8'(drive.charging), 8'h01);
        sense.in_regulation <= 1'b0;
        wait_flag(3, 1'b1, 20);
        cyc(12);
        rdchk(4'h8, 8'h18, 8'h18);
        chk(8'({drive.charging, drive.battery_switch, status_pin_o}), 8'h01);
        sense.bat_above_rechg_lo <= 1'b0;
        sense.bat_above_rechg_hi <= 1'b0;
        wait_flag(2, 1'b1, 20);
        sense.term_low <= 1'b0;
        far_u.wr(4'h3, 8'h31);
        cyc(3);
        chk(8'(status_pin_oe), 8'h00);
        far_u.wr(4'h3, 8'h01);
        sense.bat_volt <= 7'h32;
        far_u.wr(4'h2, 8'h51);
        cyc(4);
        rdchk(4'hA, 8'hFF, 8'h34);
        far_u.wr(4'h2, 8'h41);
        $display("end termination");
        far_u.wr(4'h7, 8'h02);
        rdchk(4'h8, 8'h40, 8'h00);
        source_select_pin <= 1'b1;
        cyc(6);
        rdchk(4'h0, 8'hFF, 8'h18);
        far_u.wr(4'h7, 8'h01);
        rdchk(4'h0, 8'hFF, 8'h05);
        far_u.wr(4'h0, 8'h0A);
        far_u.wr(4'h2, 8'h40);
        cyc(4);
        chk(8'({drive.charging, drive.battery_switch}), 8'h00);
        d = 8'h00;
        for (int k = 0; k < 150 && d[6] !== 1'b1; k++) far_u.rd(4'h8, d);
        chk(d & 8'h40, 8'h40);
        if (d[6] !== 1'b1) test_done();
        rdchk(4'h0, 8'hFF, 8'h0A);
        rdchk(4'h2, 8'hFF, 8'h41);
        $display("end host mode");
        sense.light_load <= 1'b1;
        far_u.wr(4'h2, 8'h40);
        cyc(5);
        chk(8'(drive.pfm_mode), 8'h01);
        far_u.wr(4'h2, 8'h42);
        cyc(5);
        chk(8'(drive.pfm_mode), 8'h00);
        sense.light_load <= 1'b0;
        sense.vbus_good <= 1'b0;
        sense.vbus_below_sleep <= 1'b1;
        sense.bat_above_boost <= 1'b1;
        far_u.wr(4'h2, 8'h4D);
        cyc(20);
        chk(8'(drive.boost_active), 8'h00);
        wait_flag(1, 1'b1, 40);
        chk(8'({drive.pfm_mode, drive.boost_ilim_hi}), 8'h03);
        rdchk(4'h8, 8'h07, 8'h07);
        cyc(55);
        chk(8'(drive.pfm_mode), 8'h00);
        sense.ts_ok <= 1'b0;
        cyc(6);
        chk(8'(drive.boost_active), 8'h00);
        sense.ts_ok <= 1'b1;
        $display("end boost");
        far_u.wr(4'h2, 8'h41);
        far_u.wr(4'h4, 8'h00);
        sense.vbus_below_sleep <= 1'b0;
        sense.bat_above_boost <= 1'b0;
        sense.vbus_good <= 1'b1;
        cyc(20);
        chk(8'({drive.converter_en, drive.charging}), 8'h02);
        far_u.wr(4'h4, 8'h20);
        wait_flag(2, 1'b1, 20);
        wait_flag(2, 1'b0, 700);
        cyc(3);
        chk(8'(drive.converter_en), 8'h01);
        rdchk(4'h8, 8'h80, 8'h80);
        d[0] = status_pin_o;
        for (int k = 0; k < 100 && status_pin_o === d[0]; k++) @(posedge clk);
        chk(8'(status_pin_o), 8'(!d[0]));
        $display("end safety timer");
        test_done();
    end
endmodule
